// ---- pkg/hbp_defines.svh ----
`ifndef HBP_DEFINES_SVH
`define HBP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
// Clock periods that pass between the hardware reset pin going low and the
// core entering its reset state.
`define HBP_RESET_CLOCKS 10
// Bus clocks that one master data cycle holds the pins.
`define HBP_DMA_CYCLES 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define HBP_STRAP_RESET 1'b0
`define HBP_SYNC_RESET 44'h0000_0000_0702

`endif

// ---- pkg/hbp_pkg.sv ----
package hbp_pkg;

    // ------------------------------------------------------------------------
    // Port sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        HBP_ST_IDLE   = 2'h0,
        HBP_ST_SLAVE  = 2'h1,
        HBP_ST_MASTER = 2'h3,
        HBP_ST_MEM    = 2'h2
    } hbp_state_e;

    // ------------------------------------------------------------------------
    // Bus cycle status codes
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        HBP_BS_IDLE   = 3'h0,
        HBP_BS_DMA_RD = 3'h1,
        HBP_BS_DMA_WR = 3'h2,
        HBP_BS_REG_RD = 3'h3,
        HBP_BS_REG_WR = 3'h4,
        HBP_BS_MEM    = 3'h5
    } hbp_status_e;

    // ------------------------------------------------------------------------
    // DMA request from the core
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic        write;
        logic        wide;
        logic [30:0] addr;
        logic [31:0] wdata;
    } hbp_dma_req_s;

endpackage

// ---- design/hbp_reset_seq.sv ----
`timescale 1ns/1ps
`include "hbp_defines.svh"

module hbp_reset_seq #(
    parameter int RESET_CLOCKS = `HBP_RESET_CLOCKS,
    parameter bit BUS_SLOWER = 1'b0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Pins
    input wire logic hw_reset_n_i,
    input wire logic tx_clk_i,
    // Core reset
    output logic core_reset_o
);
    import hbp_pkg::*;

    if (RESET_CLOCKS < 1 || RESET_CLOCKS > 15) begin : g_chk
        $error("RESET_CLOCKS must lie in 1..15");
    end

    localparam logic [3:0] LAST = 4'(RESET_CLOCKS - 1);

    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic tx_d_q;
    logic [3:0] cnt_q;
    logic core_q;

    // A bus clock slower than the transmit clock would miss transmit edges,
    // so the bus clock itself is counted in that case.
    wire tx_edge = sync_q[0] & ~tx_d_q;
    wire tick = BUS_SLOWER ? 1'b1 : tx_edge;
    wire pin_low = ~sync_q[1];
    wire at_last = (cnt_q == LAST);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= 2'h2;
            sync_q <= 2'h2;
            tx_d_q <= 1'b0;
        end else begin
            meta_q <= {hw_reset_n_i, tx_clk_i};
            sync_q <= meta_q;
            tx_d_q <= sync_q[0];
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= 4'h0;
            core_q <= 1'b0;
        end else if (!pin_low) begin
            cnt_q <= 4'h0;
            core_q <= 1'b0;
        end else if (!core_q && tick) begin
            cnt_q <= at_last ? cnt_q : cnt_q + 4'h1;
            core_q <= at_last;
        end
    end

    assign core_reset_o = core_q;

    property p_reset_after_count;
        @(posedge clk_i) disable iff (!reset_n_i)
        $rose(core_q) |-> ($past(cnt_q) == LAST) && $past(pin_low);
    endproperty
    a_reset_after_count: assert property (p_reset_after_count)
        else $error("core reset entered before the count ran out");

endmodule

// ---- design/hbp_port.sv ----
`timescale 1ns/1ps
`include "hbp_defines.svh"

module hbp_port #(
    parameter int DMA_CYCLES = `HBP_DMA_CYCLES,
    parameter bit BUS_SLOWER = 1'b0
) (
    // Clock and reset; clk_i is the system bus clock.
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Strap and reset pins
    input wire logic byte_order_strap_i,
    input wire logic hw_reset_n_i,
    input wire logic tx_clk_i,
    // Slave pins
    input wire logic chip_select_n_i,
    input wire logic slave_addr_strobe_n_i,
    input wire logic [5:0] register_select_lines_i,
    input wire logic slave_read_i,
    input wire logic shared_memory_request_n_i,
    output logic slave_memory_acknowledge_n_o,
    // Master pins
    input wire logic bus_grant_i,
    output hbp_pkg::hbp_status_e bus_cycle_status_o,
    output logic [31:1] dma_address_lines_o,
    output logic dma_address_oe_n_o,
    input wire logic [31:0] system_data_lines_i,
    output logic [31:0] system_data_lines_o,
    output logic data_lo_oe_n_o,
    output logic data_hi_oe_n_o,
    // Core DMA side
    input wire logic dma_req_valid_i,
    input wire hbp_pkg::hbp_dma_req_s dma_req_i,
    output logic dma_busy_o,
    output logic dma_done_o,
    output logic [31:0] dma_rdata_o,
    // Core register side
    input wire logic reg_avail_i,
    input wire logic mem_avail_i,
    input wire logic [15:0] reg_rdata_i,
    output logic [5:0] reg_addr_o,
    output logic reg_rd_o,
    output logic reg_wr_o,
    output logic [15:0] reg_wdata_o,
    // Mode and reset state
    output logic big_endian_o,
    output logic core_reset_o
);
    import hbp_pkg::*;

    if (DMA_CYCLES < 1 || DMA_CYCLES > 7) begin : g_chk
        $error("DMA_CYCLES must lie in 1..7");
    end

    localparam logic [2:0] DMA_LAST = 3'(DMA_CYCLES - 1);

    // In big endian mode a 32-bit word swaps its two halves on the pins.
    function automatic logic [31:0] hbp_order(input logic [31:0] d,
                                              input logic wide,
                                              input logic be);
        hbp_order = (wide && be) ? {d[15:0], d[31:16]} : d;
    endfunction

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [43:0] meta_q;
    logic [43:0] sync_q;
    wire [43:0] pins = {system_data_lines_i, byte_order_strap_i,
        chip_select_n_i, slave_addr_strobe_n_i, shared_memory_request_n_i,
        register_select_lines_i, slave_read_i, bus_grant_i};

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= `HBP_SYNC_RESET;
            sync_q <= `HBP_SYNC_RESET;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
        end
    end

    wire [31:0] data_s = sync_q[43:12];
    wire strap_s = sync_q[11];
    wire cs_n_s = sync_q[10];
    wire sas_n_s = sync_q[9];
    wire shared_memory_request_n_s = sync_q[8];
    wire [5:0] rsel_s = sync_q[7:2];
    wire read_s = sync_q[1];
    wire grant_s = sync_q[0];

    // ------------------------------------------------------------------------
    // Reset sequencing
    // ------------------------------------------------------------------------
    logic core_rst;

    hbp_reset_seq #(
        .RESET_CLOCKS(`HBP_RESET_CLOCKS),
        .BUS_SLOWER(BUS_SLOWER)
    ) u_reset_seq (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .hw_reset_n_i(hw_reset_n_i),
        .tx_clk_i(tx_clk_i),
        .core_reset_o(core_rst)
    );

    // ------------------------------------------------------------------------
    // State and output registers
    // ------------------------------------------------------------------------
    hbp_state_e state_q, state_d;
    hbp_status_e status_q, status_d;
    hbp_dma_req_s req_q, req_d;
    logic [2:0] cyc_q, cyc_d;
    logic ack_n_q, ack_n_d;
    logic aoe_n_q, aoe_n_d;
    logic lo_oe_n_q, lo_oe_n_d;
    logic hi_oe_n_q, hi_oe_n_d;
    logic [31:0] dout_q, dout_d;
    logic [31:0] rdata_q, rdata_d;
    logic done_q, done_d;
    logic rd_q, rd_d;
    logic wr_q, wr_d;
    logic [15:0] wdata_q, wdata_d;
    logic [5:0] rsel_q;
    logic strap_q;
    logic strap_taken_q;
    logic [1:0] fill_q;
    logic busy_q;
    logic core_rst_q;

    // The strap is static; it is taken once the synchronisers hold real pin
    // levels, and again whenever the core sits in reset.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            strap_q <= `HBP_STRAP_RESET;
            strap_taken_q <= 1'b0;
            fill_q <= 2'h0;
        end else begin
            fill_q <= {fill_q[0], 1'b1};
            if (fill_q[1] && (!strap_taken_q || core_rst)) begin
                strap_q <= strap_s;
                strap_taken_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rsel_q <= 6'h00;
        end else if (!sas_n_s) begin
            rsel_q <= rsel_s;
        end
    end

    wire slave_go = !cs_n_s;
    wire mem_go = !shared_memory_request_n_s;
    wire dma_go = dma_req_valid_i && grant_s;
    wire dma_end = (cyc_q == DMA_LAST);

    // Chip select is served ahead of memory request; the host keeps the two
    // apart, so the order only matters on a protocol slip.
    always_comb begin
        state_d = state_q;
        status_d = status_q;
        req_d = req_q;
        cyc_d = cyc_q;
        ack_n_d = ack_n_q;
        aoe_n_d = aoe_n_q;
        lo_oe_n_d = lo_oe_n_q;
        hi_oe_n_d = hi_oe_n_q;
        dout_d = dout_q;
        rdata_d = rdata_q;
        done_d = 1'b0;
        rd_d = 1'b0;
        wr_d = 1'b0;
        wdata_d = wdata_q;
        case (state_q)
            HBP_ST_IDLE: begin
                if (slave_go) begin
                    state_d = HBP_ST_SLAVE;
                    status_d = read_s ? HBP_BS_REG_RD : HBP_BS_REG_WR;
                end else if (mem_go) begin
                    state_d = HBP_ST_MEM;
                    status_d = HBP_BS_MEM;
                end else if (dma_go) begin
                    state_d = HBP_ST_MASTER;
                    req_d = dma_req_i;
                    cyc_d = 3'h0;
                    status_d = dma_req_i.write ? HBP_BS_DMA_WR : HBP_BS_DMA_RD;
                    aoe_n_d = 1'b0;
                    dout_d = hbp_order(dma_req_i.wdata, dma_req_i.wide,
                        strap_q);
                    lo_oe_n_d = !dma_req_i.write;
                    hi_oe_n_d = !(dma_req_i.write && dma_req_i.wide);
                end
            end
            HBP_ST_SLAVE: begin
                if (cs_n_s) begin
                    state_d = HBP_ST_IDLE;
                    status_d = HBP_BS_IDLE;
                    ack_n_d = 1'b1;
                    lo_oe_n_d = 1'b1;
                end else if (ack_n_q && reg_avail_i) begin
                    ack_n_d = 1'b0;
                    rd_d = read_s;
                    wr_d = !read_s;
                    wdata_d = data_s[15:0];
                    dout_d = {16'h0000, reg_rdata_i};
                    lo_oe_n_d = !read_s;
                end
            end
            HBP_ST_MEM: begin
                if (shared_memory_request_n_s) begin
                    state_d = HBP_ST_IDLE;
                    status_d = HBP_BS_IDLE;
                    ack_n_d = 1'b1;
                end else if (mem_avail_i) begin
                    ack_n_d = 1'b0;
                end
            end
            HBP_ST_MASTER: begin
                cyc_d = cyc_q + 3'h1;
                if (dma_end) begin
                    state_d = HBP_ST_IDLE;
                    status_d = HBP_BS_IDLE;
                    done_d = 1'b1;
                    rdata_d = req_q.write ? rdata_q
                        : hbp_order(req_q.wide ? data_s
                            : {16'h0000, data_s[15:0]}, 1'b1, strap_q);
                    aoe_n_d = 1'b1;
                    lo_oe_n_d = 1'b1;
                    hi_oe_n_d = 1'b1;
                end
            end
            default: begin
                state_d = HBP_ST_IDLE;
            end
        endcase
        if (core_rst) begin
            state_d = HBP_ST_IDLE;
            status_d = HBP_BS_IDLE;
            ack_n_d = 1'b1;
            aoe_n_d = 1'b1;
            lo_oe_n_d = 1'b1;
            hi_oe_n_d = 1'b1;
            done_d = 1'b0;
            rd_d = 1'b0;
            wr_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= HBP_ST_IDLE;
            status_q <= HBP_BS_IDLE;
            req_q <= '0;
            cyc_q <= 3'h0;
            ack_n_q <= 1'b1;
            aoe_n_q <= 1'b1;
            lo_oe_n_q <= 1'b1;
            hi_oe_n_q <= 1'b1;
            dout_q <= 32'h0000_0000;
            rdata_q <= 32'h0000_0000;
            done_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            wdata_q <= 16'h0000;
            busy_q <= 1'b0;
            core_rst_q <= 1'b0;
        end else begin
            state_q <= state_d;
            status_q <= status_d;
            req_q <= req_d;
            cyc_q <= cyc_d;
            ack_n_q <= ack_n_d;
            aoe_n_q <= aoe_n_d;
            lo_oe_n_q <= lo_oe_n_d;
            hi_oe_n_q <= hi_oe_n_d;
            dout_q <= dout_d;
            rdata_q <= rdata_d;
            done_q <= done_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            wdata_q <= wdata_d;
            busy_q <= (state_d == HBP_ST_MASTER);
            core_rst_q <= core_rst;
        end
    end

    assign slave_memory_acknowledge_n_o = ack_n_q;
    assign bus_cycle_status_o = status_q;
    assign dma_address_lines_o = req_q.addr;
    assign dma_address_oe_n_o = aoe_n_q;
    assign system_data_lines_o = dout_q;
    assign data_lo_oe_n_o = lo_oe_n_q;
    assign data_hi_oe_n_o = hi_oe_n_q;
    assign dma_busy_o = busy_q;
    assign dma_done_o = done_q;
    assign dma_rdata_o = rdata_q;
    assign reg_addr_o = rsel_q;
    assign reg_rd_o = rd_q;
    assign reg_wr_o = wr_q;
    assign reg_wdata_o = wdata_q;
    assign big_endian_o = strap_q;
    assign core_reset_o = core_rst_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    wire in_master = (state_q == HBP_ST_MASTER);

    sequence s_master_start;
        !in_master ##1 in_master;
    endsequence
    sequence s_master_last;
        in_master && dma_end && !core_rst;
    endsequence

    // The length depends on DMA_CYCLES, so it is checked through the cycle
    // counter: it starts at zero, holds ownership until the last count and
    // then lets go with the done pulse.
    property p_master_len;
        s_master_start |-> (cyc_q == 3'h0);
    endproperty
    a_master_len: assert property (p_master_len)
        else $error("master cycle did not start at count zero");

    property p_master_hold;
        in_master && !dma_end && !core_rst |=> in_master;
    endproperty
    a_master_hold: assert property (p_master_hold)
        else $error("master cycle ended early");

    property p_master_end;
        s_master_last |=> !in_master && dma_done_o;
    endproperty
    a_master_end: assert property (p_master_end)
        else $error("master cycle did not end with done");

    property p_slave_upper_float;
        (state_q == HBP_ST_SLAVE) |-> data_hi_oe_n_o;
    endproperty
    a_slave_upper_float: assert property (p_slave_upper_float)
        else $error("upper data lanes driven in slave access");

    property p_narrow_lanes;
        in_master && !req_q.wide |-> data_hi_oe_n_o;
    endproperty
    a_narrow_lanes: assert property (p_narrow_lanes)
        else $error("upper lanes driven on a 16-bit transfer");

    property p_wide_write;
        in_master && req_q.write && req_q.wide
            |-> !data_hi_oe_n_o && !data_lo_oe_n_o;
    endproperty
    a_wide_write: assert property (p_wide_write)
        else $error("32-bit write not on all lanes");

    property p_addr_float;
        in_master == !dma_address_oe_n_o;
    endproperty
    a_addr_float: assert property (p_addr_float)
        else $error("address lanes driven outside master ownership");

    property p_ack;
        (state_q != HBP_ST_IDLE) && !in_master && ack_n_q && !core_rst
            && ((state_q == HBP_ST_SLAVE) ? reg_avail_i && !cs_n_s
                : mem_avail_i && !shared_memory_request_n_s)
            |=> !slave_memory_acknowledge_n_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge missing while available");

    property p_status;
        (state_q == HBP_ST_MEM) |-> (bus_cycle_status_o == HBP_BS_MEM);
    endproperty
    a_status: assert property (p_status)
        else $error("status does not show the memory access");

    property p_strap_stable;
        strap_taken_q && !core_rst && $past(strap_taken_q)
            |-> $stable(big_endian_o);
    endproperty
    a_strap_stable: assert property (p_strap_stable)
        else $error("byte order changed outside reset");

    property p_core_reset_idle;
        core_rst |=> (state_q == HBP_ST_IDLE) && ack_n_q;
    endproperty
    a_core_reset_idle: assert property (p_core_reset_idle)
        else $error("core reset did not idle the port");

endmodule

// ---- verif/hbp_mem_model.sv ----
`timescale 1ns/1ps

module hbp_mem_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Port pins
    input wire hbp_pkg::hbp_status_e status_i,
    input wire logic [31:1] addr_i,
    input wire logic [31:0] port_data_i,
    input wire logic lo_oe_n_i,
    input wire logic hi_oe_n_i,
    // Host side, driven by the bench
    input wire logic [31:0] host_data_i,
    input wire logic host_drive_i,
    // Resolved data lines
    output logic [31:0] bus_o
);
    import hbp_pkg::*;

    logic [31:0] last_q;
    logic [31:0] mem_word;
    logic [31:0] other;
    logic mem_drive;

    // ------------------------------------------------------------------------
    // Memory answer and line resolution
    // ------------------------------------------------------------------------
    assign mem_drive = (status_i == HBP_BS_DMA_RD);
    assign mem_word = {~addr_i[16:1], addr_i[16:1]};
    // A released line shows the inverse of its last level, so that a port
    // which samples or floats at the wrong moment cannot pass by luck.
    assign other = mem_drive ? mem_word :
        host_drive_i ? host_data_i : ~last_q;
    assign bus_o[15:0] = !lo_oe_n_i ? port_data_i[15:0] : other[15:0];
    assign bus_o[31:16] = !hi_oe_n_i ? port_data_i[31:16] : other[31:16];

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            last_q <= 32'h0000_0000;
        end else begin
            last_q <= bus_o;
        end
    end
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps

module tb;
    import hbp_pkg::*;

    localparam int DC = 3;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic strap = 1'b0;
    logic hw_reset_n = 1'b1;
    logic tx_clk = 1'b0;
    logic cs_n = 1'b1;
    logic sas_n = 1'b1;
    logic [5:0] rsel = 6'h00;
    logic rd = 1'b0;
    logic shared_memory_request_n = 1'b1;
    logic ack_n;
    logic grant = 1'b0;
    hbp_status_e status;
    logic [31:1] addr;
    logic aoe_n;
    logic [31:0] bus;
    logic [31:0] dout;
    logic lo_oe_n;
    logic hi_oe_n;
    logic valid = 1'b0;
    hbp_dma_req_s req = '0;
    logic busy;
    logic done;
    logic [31:0] rdata;
    logic reg_avail = 1'b1;
    logic mem_avail = 1'b1;
    logic [15:0] reg_rdata = 16'h3c5a;
    logic [5:0] reg_addr;
    logic reg_rd;
    logic reg_wr;
    logic [15:0] reg_wdata;
    logic big_endian;
    logic core_reset;
    logic [31:0] host_data = 32'h0000_0000;
    logic host_drive = 1'b0;
    int failures = 0;
    int check_count = 0;
    int tx_cnt = 0;

    always #5 clk_i = ~clk_i;
    // The transmit clock runs free at a quarter of the bus clock rate.
    // It is offset so that its edges never meet a bus clock edge.
    initial begin
        #2;
        forever #20 tx_clk = ~tx_clk;
    end
    always @(posedge tx_clk) tx_cnt++;

    hbp_port #(.DMA_CYCLES(DC), .BUS_SLOWER(1'b0)) i_hbp_port (
        .clk_i(clk_i), .reset_n_i(reset_n_i),
        .byte_order_strap_i(strap), .hw_reset_n_i(hw_reset_n),
        .tx_clk_i(tx_clk), .chip_select_n_i(cs_n),
        .slave_addr_strobe_n_i(sas_n), .register_select_lines_i(rsel),
        .slave_read_i(rd), .shared_memory_request_n_i(shared_memory_request_n),
        .slave_memory_acknowledge_n_o(ack_n), .bus_grant_i(grant),
        .bus_cycle_status_o(status), .dma_address_lines_o(addr),
        .dma_address_oe_n_o(aoe_n), .system_data_lines_i(bus),
        .system_data_lines_o(dout), .data_lo_oe_n_o(lo_oe_n),
        .data_hi_oe_n_o(hi_oe_n), .dma_req_valid_i(valid), .dma_req_i(req),
        .dma_busy_o(busy), .dma_done_o(done), .dma_rdata_o(rdata),
        .reg_avail_i(reg_avail), .mem_avail_i(mem_avail),
        .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr), .reg_rd_o(reg_rd),
        .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata),
        .big_endian_o(big_endian), .core_reset_o(core_reset));

    hbp_mem_model i_hbp_mem_model (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .status_i(status),
        .addr_i(addr), .port_data_i(dout), .lo_oe_n_i(lo_oe_n),
        .hi_oe_n_i(hi_oe_n), .host_data_i(host_data),
        .host_drive_i(host_drive), .bus_o(bus));

    // ------------------------------------------------------------------------
    // Checking and ending
    // ------------------------------------------------------------------------
    task automatic chk_bit(input logic got, input logic exp, input string m);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %b exp %b", $time, m, got, exp);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                            input string m);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        chk_bit(ack_n, 1'b1, "ack after reset");
        chk_bit(aoe_n & lo_oe_n & hi_oe_n, 1'b1, "float after reset");
        chk_word(32'(status), 32'(HBP_BS_IDLE), "status after reset");
        $display("test reset done");
    endtask

    task automatic t_reg(input logic read, input logic late, input logic [5:0] n);
        int i;
        reg_avail = !late;
        cs_n = 1'b0;
        sas_n = 1'b0;
        rsel = n;
        rd = read;
        host_drive = !read;
        host_data = 32'hffff_a5c3;
        if (late) begin
            idle(8);
            chk_bit(ack_n, 1'b1, "ack while unavailable");
            reg_avail = 1'b1;
        end
        for (i = 0; i < 20 && ack_n !== 1'b0; i++) idle(1);
        chk_bit(ack_n, 1'b0, "register ack");
        chk_word(32'(reg_addr), 32'(n), "latched register number");
        chk_word(32'(status), read ? 32'(HBP_BS_REG_RD) : 32'(HBP_BS_REG_WR),
                 "slave status");
        chk_bit(reg_rd, read, "read pulse");
        chk_bit(reg_wr, !read, "write pulse");
        chk_bit(hi_oe_n & aoe_n, 1'b1, "upper lanes float");
        chk_bit(lo_oe_n, !read, "low lanes driven on read");
        if (read) chk_word({16'h0000, dout[15:0]}, 32'h0000_3c5a, "reg data");
        else chk_word(32'(reg_wdata), 32'h0000_a5c3, "reg write data");
        cs_n = 1'b1;
        sas_n = 1'b1;
        host_drive = 1'b0;
        idle(4);
        chk_bit(ack_n & lo_oe_n, 1'b1, "slave release");
        chk_word(32'(status), 32'(HBP_BS_IDLE), "idle status");
        idle(2);
        $display("test register %s done", read ? "read" : "write");
    endtask

    task automatic t_mem();
        int i;
        shared_memory_request_n = 1'b0;
        for (i = 0; i < 20 && ack_n !== 1'b0; i++) idle(1);
        chk_bit(ack_n, 1'b0, "memory ack");
        chk_word(32'(status), 32'(HBP_BS_MEM), "memory status");
        chk_bit(lo_oe_n & hi_oe_n & aoe_n, 1'b1, "no data on mem");
        shared_memory_request_n = 1'b1;
        idle(4);
        chk_bit(ack_n, 1'b1, "memory release");
        idle(2);
        $display("test memory request done");
    endtask

    task automatic t_dma(input logic wr, input logic wide, input logic be);
        int i;
        int n;
        logic [31:0] mem;
        req = '{wr, wide, 31'h1234_5678 ^ {29'h0, wr, wide}, 32'hc0de_1a2b};
        mem = {~req.addr[15:0], req.addr[15:0]};
        grant = 1'b1;
        valid = 1'b1;
        n = 0;
        for (i = 0; i < 30 && done !== 1'b1; i++) begin
            idle(1);
            if (busy === 1'b1) begin
                if (n == 0) begin
                    valid = 1'b0;
                    chk_word({addr, 1'b0}, {req.addr, 1'b0}, "dma address");
                    chk_bit(aoe_n, 1'b0, "address driven");
                    chk_word(32'(status), wr ? 32'(HBP_BS_DMA_WR) :
                             32'(HBP_BS_DMA_RD), "dma status");
                    chk_bit(lo_oe_n, !wr, "low lanes on write");
                    chk_bit(hi_oe_n, !(wr && wide), "high lanes");
                    if (wr && wide) chk_word(dout, be ? {req.wdata[15:0],
                        req.wdata[31:16]} : req.wdata, "wide write");
                    if (wr && !wide && !be)
                        chk_word(32'(dout[15:0]), 32'(req.wdata[15:0]),
                                 "narrow write");
                end
                n++;
            end
        end
        chk_bit(done, 1'b1, "dma done");
        chk_word(n, DC, "master cycle length");
        chk_bit(aoe_n & lo_oe_n & hi_oe_n, 1'b1, "float after dma");
        if (!wr && wide) chk_word(rdata, be ? {mem[15:0], mem[31:16]} : mem,
                                  "wide read");
        if (!wr && !wide) chk_word(rdata, be ? {mem[15:0], 16'h0000} :
                                   {16'h0000, mem[15:0]}, "narrow read");
        grant = 1'b0;
        idle(2);
        $display("test dma wr %b wide %b be %b done", wr, wide, be);
    endtask

    task automatic t_hw_reset();
        int i;
        int start;
        strap = 1'b1;
        hw_reset_n = 1'b0;
        start = tx_cnt;
        for (i = 0; i < 200 && core_reset !== 1'b1; i++) idle(1);
        chk_bit((tx_cnt - start) inside {10, 11}, 1'b1, "reset delay");
        chk_bit(core_reset, 1'b1, "core reset entered");
        chk_bit(ack_n & aoe_n & lo_oe_n & hi_oe_n, 1'b1, "float in reset");
        idle(2);
        chk_bit(big_endian, 1'b1, "strap recaptured");
        hw_reset_n = 1'b1;
        for (i = 0; i < 10 && core_reset !== 1'b0; i++) idle(1);
        chk_bit(core_reset, 1'b0, "core reset left");
        idle(2);
        $display("test hardware reset done");
    endtask

    initial begin
        #100_000;
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        int k;
        idle(8);
        reset_n_i = 1'b1;
        idle(1);
        t_reset();
        chk_bit(big_endian, 1'b0, "little endian strap");
        idle(2);
        t_reg(1'b1, 1'b0, 6'h2a);
        t_reg(1'b0, 1'b1, 6'h3f);
        t_mem();
        t_reg(1'b1, 1'b1, 6'h00);
        for (k = 0; k < 4; k++) t_dma(k[1], k[0], 1'b0);
        t_hw_reset();
        for (k = 0; k < 4; k++) t_dma(k[1], k[0], 1'b1);
        end_sim();
    end
endmodule
